// *** src/exec_pkg.sv ***
package exec_pkg;

    // ==================================================================
    // widths
    localparam int PC_W    = 21;
    localparam int FLAGS_W = 5;
    localparam int BSR_W   = 4;
    localparam int FILE_AW = BSR_W + 8;

    // ==================================================================
    // register byte offsets on the bus
    localparam logic [7:0] ADR_INSTR  = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_CONFIG = 8'h08;
    localparam logic [7:0] ADR_W      = 8'h0c;
    localparam logic [7:0] ADR_FLAGS  = 8'h10;
    localparam logic [7:0] ADR_BSR    = 8'h14;
    localparam logic [7:0] ADR_WS     = 8'h18;
    localparam logic [7:0] ADR_FS     = 8'h1c;
    localparam logic [7:0] ADR_BS     = 8'h20;
    localparam logic [7:0] ADR_PC     = 8'h24;
    localparam logic [7:0] ADR_PCU    = 8'h28;
    localparam logic [7:0] ADR_PCH    = 8'h2c;
    localparam logic [7:0] ADR_INDEX  = 8'h30;
    localparam logic [7:0] ADR_DADDR  = 8'h34;
    localparam logic [7:0] ADR_DDATA  = 8'h38;

    // ==================================================================
    // field positions
    localparam int FLAG_C      = 0;
    localparam int FLAG_DC     = 1;
    localparam int FLAG_Z      = 2;
    localparam int FLAG_OV     = 3;
    localparam int FLAG_N      = 4;
    localparam int STAT_BUSY   = 0;
    localparam int STAT_UNKN   = 1;
    localparam int CFG_EXT_EN  = 0;

    // ==================================================================
    // opcode patterns and addressing
    localparam logic [14:0] RET_PATTERN   = 15'h0009;
    localparam logic [5:0]  ROT_PREFIX    = 6'h0d;
    localparam logic [7:0]  INDEXED_LAST  = 8'h5f;
    localparam logic [7:0]  ACCESS_SPLIT  = 8'h80;
    localparam logic [3:0]  ACCESS_HIGH   = 4'hf;

    // ==================================================================
    // reset values
    localparam logic [15:0] INSTR_RST = 16'h0000;
    localparam logic [7:0]  BYTE_RST  = 8'h00;
    localparam logic [4:0]  FLAGS_RST = 5'h00;
    localparam logic [3:0]  BSR_RST   = 4'h0;
    localparam logic [20:0] PC_RST    = 21'h000000;
    localparam logic [11:0] ADDR_RST  = 12'h000;

    // ==================================================================
    // instruction-cycle phases and sequencer states
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_EXEC = 2'h1,
        ST_NOP  = 2'h3
    } exec_state_t;

endpackage

// *** src/file_ram.sv ***
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// single-port data memory, registered read
module file_ram #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input  wire logic          clk_i,   // core clock
    input  wire logic          we_i,    // write strobe
    input  wire logic [AW-1:0] addr_i,  // byte address
    input  wire logic [DW-1:0] wdata_i, // write data
    output var  logic [DW-1:0] rdata_o  // data of previous address
);

    logic [DW-1:0] mem [0:(2**AW)-1];

    // read returns old contents on a same-address write
    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end

endmodule
`default_nettype wire

// *** src/subroutine_exit_and_rotate_exec.sv ***
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// execution of subroutine exit and rotate-left-through-carry
module subroutine_exit_and_rotate_exec
    import exec_pkg::*;
(
    input  wire logic            clk_i,       // core clock, 20 MHz
    input  wire logic            rst_i,       // sync reset, high
    input  wire logic            wb_cyc_i,    // bus cycle
    input  wire logic            wb_stb_i,    // bus strobe
    input  wire logic            wb_we_i,     // bus write
    input  wire logic [7:0]      wb_adr_i,    // byte address
    input  wire logic [3:0]      wb_sel_i,    // byte lanes
    input  wire logic [31:0]     wb_dat_i,    // write data
    output var  logic [31:0]     wb_dat_o,    // read data
    output var  logic            wb_ack_o,    // bus acknowledge
    input  wire logic [PC_W-1:0] stack_top_i, // return stack top
    output var  logic            stack_pop_o, // pop strobe, phase four
    output var  logic [PC_W-1:0] pc_o,        // program counter
    output var  logic            busy_o       // instruction in flight
);

    // ==================================================================
    // state
    exec_state_t          state;
    logic [1:0]           q;
    logic [15:0]          ir;
    logic                 pending;
    logic                 unknown_op;
    logic                 ext_en;
    logic [7:0]           w;
    logic [7:0]           working_shadow;
    logic [FLAGS_W-1:0]   flags;
    logic [FLAGS_W-1:0]   flags_shadow;
    logic [BSR_W-1:0]     bank_select_register;
    logic [BSR_W-1:0]     bank_select_shadow;
    logic [PC_W-1:0]      pc;
    logic [4:0]           pc_upper_latch;
    logic [7:0]           pc_high_latch;
    logic [FILE_AW-1:0]   index_base;
    logic [FILE_AW-1:0]   daddr;
    logic [7:0]           res;
    logic                 res_c;
    logic                 idle_q;
    logic [7:0]           mem_rdata;

    // ==================================================================
    // instruction decode
    wire                is_ret    = (ir[15:1] == RET_PATTERN);
    wire                restore   = ir[0];
    wire                is_rot    = (ir[15:10] == ROT_PREFIX);
    wire                dest_file = ir[9];
    wire                bank_a    = ir[8];
    wire [7:0]          fadr      = ir[7:0];
    wire                in_exec   = (state == ST_EXEC);
    wire                ret_q4    = in_exec & is_ret & (q == Q4);
    wire                rot_q3    = in_exec & is_rot & (q == Q3);
    wire                rot_q4    = in_exec & is_rot & (q == Q4);
    wire                take      = (state == ST_IDLE) & pending
                                    & (q == Q4);

    // file address: banked, indexed or access bank
    wire                indexed   = ~bank_a & ext_en
                                    & (fadr <= INDEXED_LAST);
    wire [FILE_AW-1:0]  idx_addr  = index_base
                                    + {{(FILE_AW-8){1'b0}}, fadr};
    wire [FILE_AW-1:0]  acc_addr  = (fadr < ACCESS_SPLIT)
                                    ? {{(FILE_AW-8){1'b0}}, fadr}
                                    : {ACCESS_HIGH, fadr};
    wire [FILE_AW-1:0]  eff_addr  = bank_a ? {bank_select_register, fadr}
                                    : indexed ? idx_addr
                                    : acc_addr;

    // rotate datapath: old carry in at bit 0, bit 7 out to carry
    wire [7:0]          rot_val   = {mem_rdata[6:0], flags[FLAG_C]};

    // ==================================================================
    // bus decode; core registers only move while the core is idle
    wire                bus_ok    = (state == ST_IDLE) & ~pending & idle_q;
    wire                bus_go    = wb_cyc_i & wb_stb_i & ~wb_ack_o
                                    & (bus_ok | (wb_adr_i == ADR_STATUS));
    wire                bus_wr    = bus_go & wb_we_i;
    wire [31:0]         wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire                wr_instr  = bus_wr & (wb_adr_i == ADR_INSTR);
    wire                wr_cfg    = bus_wr & (wb_adr_i == ADR_CONFIG);
    wire                wr_w      = bus_wr & (wb_adr_i == ADR_W);
    wire                wr_flags  = bus_wr & (wb_adr_i == ADR_FLAGS);
    wire                wr_bsr    = bus_wr & (wb_adr_i == ADR_BSR);
    wire                wr_ws     = bus_wr & (wb_adr_i == ADR_WS);
    wire                wr_fs     = bus_wr & (wb_adr_i == ADR_FS);
    wire                wr_bs     = bus_wr & (wb_adr_i == ADR_BS);
    wire                wr_pc     = bus_wr & (wb_adr_i == ADR_PC);
    wire                wr_pcu    = bus_wr & (wb_adr_i == ADR_PCU);
    wire                wr_pch    = bus_wr & (wb_adr_i == ADR_PCH);
    wire                wr_index  = bus_wr & (wb_adr_i == ADR_INDEX);
    wire                wr_daddr  = bus_wr & (wb_adr_i == ADR_DADDR);
    wire                wr_ddata  = bus_wr & (wb_adr_i == ADR_DDATA)
                                    & wb_sel_i[0];

    function automatic logic [31:0] merge(input logic [31:0] old);
        return (old & ~wmask) | (wb_dat_i & wmask);
    endfunction

    // read selection, unmapped offsets read as zero
    wire [31:0] stat_word = {30'h0, unknown_op, pending | ~idle_q
                             | (state != ST_IDLE)};
    wire [31:0] rd_mux =
        (wb_adr_i == ADR_INSTR)  ? {16'h0, ir} :
        (wb_adr_i == ADR_STATUS) ? stat_word :
        (wb_adr_i == ADR_CONFIG) ? {31'h0, ext_en} :
        (wb_adr_i == ADR_W)      ? {24'h0, w} :
        (wb_adr_i == ADR_FLAGS)  ? {27'h0, flags} :
        (wb_adr_i == ADR_BSR)    ? {28'h0, bank_select_register} :
        (wb_adr_i == ADR_WS)     ? {24'h0, working_shadow} :
        (wb_adr_i == ADR_FS)     ? {27'h0, flags_shadow} :
        (wb_adr_i == ADR_BS)     ? {28'h0, bank_select_shadow} :
        (wb_adr_i == ADR_PC)     ? {11'h0, pc} :
        (wb_adr_i == ADR_PCU)    ? {27'h0, pc_upper_latch} :
        (wb_adr_i == ADR_PCH)    ? {24'h0, pc_high_latch} :
        (wb_adr_i == ADR_INDEX)  ? {20'h0, index_base} :
        (wb_adr_i == ADR_DADDR)  ? {20'h0, daddr} :
        (wb_adr_i == ADR_DDATA)  ? {24'h0, mem_rdata} :
        32'h0;

    // memory port: core owns it while executing
    wire [FILE_AW-1:0] mem_addr  = in_exec ? eff_addr : daddr;
    wire               mem_we    = (rot_q4 & dest_file) | wr_ddata;
    wire [7:0]         mem_wdata = in_exec ? res : wb_dat_i[7:0];

    file_ram #(
        .AW (FILE_AW),
        .DW (8)
    ) u_file_ram (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .addr_i  (mem_addr),
        .wdata_i (mem_wdata),
        .rdata_o (mem_rdata)
    );

    // ==================================================================
    // bus answer: one cycle after the request is seen
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= bus_go;
            wb_dat_o <= bus_go ? rd_mux : 32'h0;
        end
    end

    // phase counter and sequencer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q      <= Q1;
            state  <= ST_IDLE;
            idle_q <= 1'b0;
        end
        else
        begin
            q      <= q + 2'h1;
            idle_q <= (state == ST_IDLE);
            case (state)
                ST_IDLE: state <= take ? ST_EXEC : ST_IDLE;
                ST_EXEC: state <= (q != Q4) ? ST_EXEC
                                  : is_ret ? ST_NOP
                                  : ST_IDLE;
                ST_NOP:  state <= (q == Q4) ? ST_IDLE : ST_NOP;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // instruction word, start request and decode error
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ir         <= INSTR_RST;
            pending    <= 1'b0;
            unknown_op <= 1'b0;
            ext_en     <= 1'b0;
        end
        else
        begin
            ir         <= wr_instr ? 16'(merge({16'h0, ir})) : ir;
            pending    <= wr_instr | (pending & ~take);
            unknown_op <= (in_exec & (q == Q4) & ~is_ret & ~is_rot)
                          | (unknown_op & ~wr_instr);
            ext_en     <= wr_cfg ? wb_dat_i[CFG_EXT_EN] : ext_en;
        end
    end

    // rotate: read in phase two, process in phase three
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            res   <= BYTE_RST;
            res_c <= 1'b0;
        end
        else if (rot_q3)
        begin
            res   <= rot_val;
            res_c <= mem_rdata[7];
        end
    end

    // working register: bus, rotate result or shadow restore
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            w <= BYTE_RST;
        else if (wr_w)
            w <= 8'(merge({24'h0, w}));
        else if (rot_q4 & ~dest_file)
            w <= res;
        else if (ret_q4 & restore)
            w <= working_shadow;
    end

    // flags: rotate updates carry, zero, negative; exit only restores
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            flags <= FLAGS_RST;
        else if (wr_flags)
            flags <= 5'(merge({27'h0, flags}));
        else if (rot_q4)
        begin
            flags[FLAG_C] <= res_c;
            flags[FLAG_Z] <= (res == 8'h00);
            flags[FLAG_N] <= res[7];
        end
        else if (ret_q4 & restore)
            flags <= flags_shadow;
    end

    // bank select and program counter; latches move only from the bus
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bank_select_register <= BSR_RST;
            pc                   <= PC_RST;
            pc_upper_latch       <= 5'h00;
            pc_high_latch        <= BYTE_RST;
        end
        else
        begin
            if (wr_bsr)
                bank_select_register <= 4'(merge({28'h0,
                                        bank_select_register}));
            else if (ret_q4 & restore)
                bank_select_register <= bank_select_shadow;
            if (wr_pc)
                pc <= 21'(merge({11'h0, pc}));
            else if (ret_q4)
                pc <= stack_top_i;
            if (wr_pcu)
                pc_upper_latch <= 5'(merge({27'h0, pc_upper_latch}));
            if (wr_pch)
                pc_high_latch <= 8'(merge({24'h0, pc_high_latch}));
        end
    end

    // shadows and memory pointers, software loaded
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            working_shadow     <= BYTE_RST;
            flags_shadow       <= FLAGS_RST;
            bank_select_shadow <= BSR_RST;
            index_base         <= ADDR_RST;
            daddr              <= ADDR_RST;
        end
        else
        begin
            if (wr_ws)
                working_shadow <= 8'(merge({24'h0, working_shadow}));
            if (wr_fs)
                flags_shadow <= 5'(merge({27'h0, flags_shadow}));
            if (wr_bs)
                bank_select_shadow <= 4'(merge({28'h0,
                                      bank_select_shadow}));
            if (wr_index)
                index_base <= 12'(merge({20'h0, index_base}));
            if (wr_daddr)
                daddr <= 12'(merge({20'h0, daddr}));
        end
    end

    // pop strobe is high through phase four of the exit
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stack_pop_o <= 1'b0;
            pc_o        <= PC_RST;
            busy_o      <= 1'b0;
        end
        else
        begin
            stack_pop_o <= in_exec & is_ret & (q == Q3);
            pc_o        <= wr_pc ? 21'(merge({11'h0, pc}))
                           : ret_q4 ? stack_top_i : pc;
            busy_o      <= wr_instr | pending | (state != ST_IDLE);
        end
    end

    // ==================================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_pop_loads_pc: assert property (
        ret_q4 |-> stack_pop_o ##1 (pc == $past(stack_top_i)))
        else $error("exit did not load pc from stack");

    a_shadow_restore: assert property (
        (ret_q4 && restore) |=> (w == $past(working_shadow)
            && flags == $past(flags_shadow)
            && bank_select_register == $past(bank_select_shadow)))
        else $error("shadow restore missing");

    a_no_restore: assert property (
        (ret_q4 && !restore) |=> ($stable(w) && $stable(flags)
            && $stable(bank_select_register)))
        else $error("exit without restore changed registers");

    a_exit_latches: assert property (
        (is_ret && state != ST_IDLE) |=> ($stable(pc_upper_latch)
            && $stable(pc_high_latch)))
        else $error("exit touched pc latches");

    a_exit_two_cycles: assert property (
        ret_q4 |=> (state == ST_NOP && !stack_pop_o) [*4]
            ##1 state == ST_IDLE)
        else $error("exit second cycle wrong");

    a_exit_decode: assert property (
        stack_pop_o |-> (ir[15:1] == 15'h0009 && q == Q4))
        else $error("pop without exit opcode");

    a_rotate_value: assert property (
        rot_q3 |-> ##2 (flags[FLAG_C] == $past(mem_rdata[7], 2)
            && flags[FLAG_N] == $past(mem_rdata[6], 2)
            && flags[FLAG_Z] == ($past(mem_rdata[6:0], 2) == 7'h00
                && !$past(flags[FLAG_C], 2))))
        else $error("rotate flags wrong");

    a_rotate_dest: assert property (
        (rot_q4 && !dest_file) |-> !mem_we ##1 (w == $past(res)))
        else $error("rotate to working register wrong");

    a_bank_select: assert property (
        (in_exec && is_rot && bank_a) |->
            mem_addr == {bank_select_register, fadr})
        else $error("banked address wrong");

    a_indexed_mode: assert property (
        (in_exec && is_rot && !bank_a && ext_en && fadr <= 8'h5f) |->
            mem_addr == 12'(index_base + {4'h0, fadr}))
        else $error("indexed address wrong");

    a_rotate_one_cycle: assert property (
        (in_exec && is_rot && q == Q1) |-> ##3 (rot_q4 && mem_we == dest_file)
            ##1 state == ST_IDLE)
        else $error("rotate not one cycle");

endmodule
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// bench for subroutine exit and rotate execution
module tb;
    import exec_pkg::*;
    typedef struct packed
    {
        logic [15:0] op;
        logic        ext;
        logic [11:0] pa;
        logic [7:0]  v;
        logic        c;
    } row_t;
    logic            clk_i       = 1'b0;
    logic            rst_i       = 1'b1;
    logic            wb_cyc_i    = 1'b0;
    logic            wb_stb_i    = 1'b0;
    logic            wb_we_i     = 1'b0;
    logic [7:0]      wb_adr_i    = 8'h00;
    logic [3:0]      wb_sel_i    = 4'hf;
    logic [31:0]     wb_dat_i    = 32'h0;
    logic [31:0]     wb_dat_o;
    logic            wb_ack_o;
    logic [PC_W-1:0] stack_top_i = 21'h0;
    logic            stack_pop_o;
    logic [PC_W-1:0] pc_o;
    logic            busy_o;
    logic [31:0]     rdat;
    logic [7:0]      res;
    int              bad_count   = 0;
    int              comparisons = 0;
    int              pops        = 0;
    int              p0;
    row_t            r;
    // opcode, ext, physical byte, value, carry in
    row_t rows [6] = '{
        '{16'h3410, 1'b0, 12'h010, 8'he6, 1'b0},
        '{16'h3690, 1'b0, 12'hf90, 8'h80, 1'b1},
        '{16'h3722, 1'b0, 12'h222, 8'h00, 1'b0},
        '{16'h3420, 1'b1, 12'h320, 8'h40, 1'b0},
        '{16'h365f, 1'b1, 12'h35f, 8'h7f, 1'b1},
        '{16'h3660, 1'b1, 12'h060, 8'h01, 1'b0}};
    logic [7:0] ea [8] = '{8'h0c, 8'h10, 8'h14, 8'h18,
                           8'h1c, 8'h20, 8'h28, 8'h2c};
    logic [7:0] ev [8] = '{8'h11, 8'h0a, 8'h02, 8'ha5,
                           8'h15, 8'h07, 8'h1f, 8'hab};

    subroutine_exit_and_rotate_exec subroutine_exit_and_rotate_exec_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .stack_top_i(stack_top_i),
        .stack_pop_o(stack_pop_o), .pc_o(pc_o), .busy_o(busy_o));

    // ==================================================================
    // clock and pop counter
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        if (stack_pop_o === 1'b1) pops <= pops + 1;
    end

    // ==================================================================
    // helpers
    task automatic finish_test;
        $display("checks %0d errors %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // one classic cycle, held until ack is seen
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == 100) begin bad_count++; finish_test(); end
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(rdat, e);
    endtask
    // start an instruction and poll until the core is idle
    task automatic exec(input logic [15:0] op);
        int n;
        bus(ADR_INSTR, 1'b1, {16'h0, op});
        rdat = 32'h1;
        for (n = 0; n < 50 && rdat[0] !== 1'b0; n++)
            bus(ADR_STATUS, 1'b0, 32'h0);
        if (n == 50) begin bad_count++; finish_test(); end
    endtask

    // ==================================================================
    // main sequence
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(pc_o, 32'h0);
        chk(busy_o, 1'b0);
        bus(ADR_BSR, 1'b1, 32'h2);
        bus(ADR_INDEX, 1'b1, 32'h300);
        for (int i = 0; i < 6; i++)
        begin
            r = rows[i];
            bus(ADR_CONFIG, 1'b1, {31'h0, r.ext});
            bus(ADR_DADDR, 1'b1, {20'h0, r.pa});
            bus(ADR_DDATA, 1'b1, {24'h0, r.v});
            bus(ADR_FLAGS, 1'b1, {27'h0, 4'h5, r.c});
            bus(ADR_W, 1'b1, 32'h5a);
            exec(r.op);
            res = {r.v[6:0], r.c};
            rchk(ADR_FLAGS, {res[7], 1'b1, res == 8'h0, 1'b1, r.v[7]});
            bus(ADR_DADDR, 1'b1, {20'h0, r.pa});
            rchk(ADR_DDATA, r.op[9] ? res : r.v);
            rchk(ADR_W, r.op[9] ? 8'h5a : res);
        end
        // subroutine exit without and with shadow restore
        for (int s = 0; s < 2; s++)
        begin
            for (int j = 0; j < 8; j++) bus(ea[j], 1'b1, {24'h0, ev[j]});
            stack_top_i <= 21'h1abcd0 | s;
            p0 = pops;
            exec(16'h0012 | s);
            chk(pops - p0, 1);
            chk(pc_o, 21'h1abcd0 | s);
            for (int j = 0; j < 8; j++)
                rchk(ea[j], (s == 1 && j < 3) ? ev[j + 3] : ev[j]);
        end
        // a neighbouring pattern is not an exit
        p0 = pops;
        exec(16'h0010);
        rchk(ADR_STATUS, 32'h2);
        chk(pops - p0, 0);
        // unmapped word reads zero and ignores writes
        bus(8'h3c, 1'b1, 32'hffffffff);
        rchk(8'h3c, 32'h0);
        // reset in mid-run
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(pc_o, 32'h0);
        rchk(ADR_W, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
